// ==== include/dram_seq_pkg.sv ====
// Constants and types shared by the interleaved DRAM state sequencer.
package dram_seq_pkg;
  localparam int unsigned CLOCK_HZ = 10000000;
  localparam int unsigned ADDR_WIDTH = 32;
  localparam int unsigned BANK_BIT = 2;
  localparam int unsigned SELECT_COUNT = 5;
  localparam int unsigned ROW_STROBE_CLOCKS = 2;
  localparam int unsigned PRECHARGE_CLOCKS = 2;
  localparam logic [2:0] SEQ_COUNT_ZERO = 3'h0;
  localparam logic RESET_ROW_STROBE_N = 1'b1;
  localparam logic RESET_ROW_SELECT = 1'b1;
  localparam logic RESET_MUX_ENABLE_N = 1'b0;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ROW,
    ST_COLUMN,
    ST_REFRESH,
    ST_PRECHARGE
  } seq_state_t;
endpackage

// ==== hdl/input_sync.sv ====
// Three-stage synchroniser with agreement filter for pin-level inputs.
`timescale 1ns/10ps
`default_nettype none
module input_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pin,
  input wire logic [WIDTH-1:0] reset_value,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic primed;

  // The reset value is loaded once, after release, so that no port feeds an async load.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
      primed <= 1'b0;
    end
    else
    begin
      stage1 <= pin;
      primed <= 1'b1;
      if (!primed)
      begin
        // The later stages start at the reset value too; cleared, they would agree on zero.
        stage2 <= reset_value;
        stage3 <= reset_value;
        level <= reset_value;
      end
      else
      begin
        stage2 <= stage1;
        stage3 <= stage2;
        for (int i = 0; i < int'(WIDTH); i++)
        begin
          if (stage2[i] == stage3[i])
          begin
            level[i] <= stage3[i];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/dram_state_sequencer.sv ====
// Interleaved two-bank DRAM state sequencer.
//
// Overview of operation
// - Start cycles and track them until done.
// - Accept bus-master and refresh requests.
// - Access when all selects active; else queue.
// - Sample selects at phase start; clear queue.
// - Address bit two picks bank at start.
// - Refresh request mid-phase starts refresh soon.
// - Two row strobes, two mux controls registered.
// - Row strobes change only at phase start.
// - Mux enable off in refresh; mid-phase changes.
// - Keep registered copy of active bank.
// - Registered on fast clock; phase sampled always.
// - Ignore inputs when setup is unsafe.
// - Phase start and middle edges defined.
`timescale 1ns/10ps
`default_nettype none
module dram_state_sequencer
  import dram_seq_pkg::*;
#(
  parameter int unsigned ROW_CLOCKS = ROW_STROBE_CLOCKS,
  parameter int unsigned PRE_CLOCKS = PRECHARGE_CLOCKS
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic phase,
  input wire logic select_in_0_n,
  input wire logic select_in_1_n,
  input wire logic select_in_2_n,
  input wire logic select_in_3_n,
  input wire logic select_in_4_n,
  input wire logic bank_address_bit,
  input wire logic refresh_request,
  output logic bank0_row_strobe_n,
  output logic bank1_row_strobe_n,
  output logic row_column_select,
  output logic addr_mux_enable_n
);
  // Idle levels: all five selects high, phase, bank and refresh low.
  // Phase starts low so that no false start edge follows reset.
  localparam logic [7:0] SYNC_RESET = 8'h3E;

  typedef struct packed {
    seq_state_t state;
    logic [2:0] count;
    logic pending_request_flag;
    logic active_bank_reg;
    logic bank0_row_strobe_n;
    logic bank1_row_strobe_n;
    logic row_column_select;
    logic addr_mux_enable_n;
    logic phase_prev;
  } seq_regs_t;

  seq_regs_t cur;
  seq_regs_t next_cur;
  logic [7:0] sync_level;
  logic all_selected;
  logic start_edge;
  logic middle_edge;
  logic want_refresh;

  // Phase, selects and refresh come from other logic, so they pass the agreement filter.
  input_sync #(.WIDTH(8)) sync_inputs
  (
    .clk(clk),
    .rstn(rstn),
    .pin({refresh_request, bank_address_bit, select_in_4_n, select_in_3_n,
      select_in_2_n, select_in_1_n, select_in_0_n, phase}),
    .reset_value(SYNC_RESET),
    .level(sync_level)
  );

  // A start-of-phase edge follows phase going high; every other clock edge counts as mid-phase.
  assign start_edge = sync_level[0] && !cur.phase_prev;
  assign middle_edge = !start_edge;
  assign all_selected = ~|sync_level[5:1];
  assign want_refresh = sync_level[7];

  always_comb
  begin
    next_cur = cur;
    next_cur.phase_prev = sync_level[0];
    if (start_edge)
    begin
      // Selects are only looked at on the start edge; other samples are masked.
      if (all_selected && cur.state != ST_IDLE)
      begin
        next_cur.pending_request_flag = 1'b1;
      end
      unique case (cur.state)
        ST_IDLE:
        begin
          if (all_selected || cur.pending_request_flag)
          begin
            next_cur.state = ST_ROW;
            next_cur.active_bank_reg = sync_level[6];
            next_cur.bank0_row_strobe_n = sync_level[6];
            next_cur.bank1_row_strobe_n = !sync_level[6];
            next_cur.count = SEQ_COUNT_ZERO;
            next_cur.pending_request_flag = 1'b0;
          end
        end
        ST_ROW:
        begin
          next_cur.state = ST_COLUMN;
        end
        ST_COLUMN:
        begin
          next_cur.count = cur.count + 3'h1;
          if (cur.count >= 3'(ROW_CLOCKS - 1))
          begin
            next_cur.bank0_row_strobe_n = 1'b1;
            next_cur.bank1_row_strobe_n = 1'b1;
            next_cur.state = ST_PRECHARGE;
            next_cur.count = SEQ_COUNT_ZERO;
          end
        end
        ST_REFRESH:
        begin
          next_cur.count = cur.count + 3'h1;
          if (cur.count >= 3'(ROW_CLOCKS - 1))
          begin
            next_cur.bank0_row_strobe_n = 1'b1;
            next_cur.bank1_row_strobe_n = 1'b1;
            next_cur.state = ST_PRECHARGE;
            next_cur.count = SEQ_COUNT_ZERO;
          end
          else
          begin
            next_cur.bank0_row_strobe_n = 1'b0;
            next_cur.bank1_row_strobe_n = 1'b0;
          end
        end
        ST_PRECHARGE:
        begin
          next_cur.count = cur.count + 3'h1;
          if (cur.count >= 3'(PRE_CLOCKS - 1))
          begin
            next_cur.state = ST_IDLE;
          end
        end
      endcase
    end
    else if (middle_edge)
    begin
      // Mux controls move mid-phase, at least one clock away from the strobes.
      if (cur.state == ST_ROW)
      begin
        next_cur.row_column_select = 1'b0;
      end
      else if (cur.state == ST_PRECHARGE || cur.state == ST_IDLE)
      begin
        next_cur.row_column_select = 1'b1;
        next_cur.addr_mux_enable_n = 1'b0;
      end
      // Refresh beats a queued access but never cuts into a running one.
      if (cur.state == ST_IDLE && want_refresh)
      begin
        next_cur.state = ST_REFRESH;
        next_cur.count = SEQ_COUNT_ZERO;
        next_cur.addr_mux_enable_n = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cur.state <= ST_IDLE;
      cur.count <= SEQ_COUNT_ZERO;
      cur.pending_request_flag <= 1'b0;
      cur.active_bank_reg <= 1'b0;
      cur.bank0_row_strobe_n <= RESET_ROW_STROBE_N;
      cur.bank1_row_strobe_n <= RESET_ROW_STROBE_N;
      cur.row_column_select <= RESET_ROW_SELECT;
      cur.addr_mux_enable_n <= RESET_MUX_ENABLE_N;
      cur.phase_prev <= 1'b1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign bank0_row_strobe_n = cur.bank0_row_strobe_n;
  assign bank1_row_strobe_n = cur.bank1_row_strobe_n;
  assign row_column_select = cur.row_column_select;
  assign addr_mux_enable_n = cur.addr_mux_enable_n;

  a_strobe_phase: assert property (@(posedge clk) disable iff (!rstn)
    ($changed(bank0_row_strobe_n) || $changed(bank1_row_strobe_n)) |-> $past(start_edge))
    else $error("Row strobe moved off a phase start.");
  a_mux_phase: assert property (@(posedge clk) disable iff (!rstn)
    ($changed(row_column_select) || $changed(addr_mux_enable_n)) |-> !$past(start_edge))
    else $error("Mux control moved off a phase middle.");
  a_refresh_mux: assert property (@(posedge clk) disable iff (!rstn)
    cur.state == ST_REFRESH |-> addr_mux_enable_n)
    else $error("Mux enabled during refresh.");
  a_one_bank: assert property (@(posedge clk) disable iff (!rstn)
    (cur.state == ST_COLUMN) |-> (bank0_row_strobe_n == cur.active_bank_reg)
      && (bank1_row_strobe_n != cur.active_bank_reg))
    else $error("Wrong bank strobed during access.");
  a_start_access: assert property (@(posedge clk) disable iff (!rstn)
    (start_edge && cur.state == ST_IDLE && all_selected) |=> cur.state == ST_ROW)
    else $error("Selected access did not start.");
  a_queue_set: assert property (@(posedge clk) disable iff (!rstn)
    (start_edge && cur.state != ST_IDLE && all_selected) |=> cur.pending_request_flag)
    else $error("Busy request not queued.");
  a_queue_clear: assert property (@(posedge clk) disable iff (!rstn)
    (cur.state == ST_ROW) |-> !cur.pending_request_flag)
    else $error("Queue not cleared at access start.");
  a_refresh_go: assert property (@(posedge clk) disable iff (!rstn)
    (middle_edge && cur.state == ST_IDLE && want_refresh) |=> cur.state == ST_REFRESH)
    else $error("Refresh not started.");
  c_access: cover property (@(posedge clk) disable iff (!rstn) cur.state == ST_COLUMN);
  c_refresh: cover property (@(posedge clk) disable iff (!rstn) cur.state == ST_REFRESH);
  c_queued: cover property (@(posedge clk) disable iff (!rstn) cur.pending_request_flag);
endmodule
`default_nettype wire

// ==== dv/phase_source.sv ====
// Far-side stand-in: processor phase source and per-bank row strobe counters.
`timescale 1ns/10ps
`default_nettype none
module phase_source
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic bank0_row_strobe_n,
  input wire logic bank1_row_strobe_n,
  output logic phase,
  output int hits0,
  output int hits1
);
  logic half;
  logic b0_q;
  logic b1_q;
  // The phase runs free, as the processor clock does; it divides the double-rate clock by four.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      half <= 1'b0;
      phase <= 1'b0;
      hits0 <= 0;
      hits1 <= 0;
      b0_q <= 1'b1;
      b1_q <= 1'b1;
    end
    else
    begin
      half <= ~half;
      if (half)
        phase <= ~phase;
      b0_q <= bank0_row_strobe_n;
      b1_q <= bank1_row_strobe_n;
      if (b0_q && !bank0_row_strobe_n)
        hits0 <= hits0 + 1;
      if (b1_q && !bank1_row_strobe_n)
        hits1 <= hits1 + 1;
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the interleaved DRAM state sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, rstn, phase, rfq, bank;
  logic [4:0] sel_n;
  logic b0, b1, rcs, mux;
  int err_total, checks_done, hits0, hits1;
  dram_state_sequencer dram_state_sequencer_i (.clk(clk), .rstn(rstn), .phase(phase),
    .select_in_0_n(sel_n[0]), .select_in_1_n(sel_n[1]), .select_in_2_n(sel_n[2]),
    .select_in_3_n(sel_n[3]), .select_in_4_n(sel_n[4]), .bank_address_bit(bank),
    .refresh_request(rfq), .bank0_row_strobe_n(b0), .bank1_row_strobe_n(b1),
    .row_column_select(rcs), .addr_mux_enable_n(mux));
  phase_source phase_source_i (.clk(clk), .rstn(rstn), .bank0_row_strobe_n(b0),
    .bank1_row_strobe_n(b1), .phase(phase), .hits0(hits0), .hits1(hits1));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int w);
    return w == 0 ? b0 : w == 1 ? b1 : w == 2 ? rcs : mux;
  endfunction
  // Polls one output; a bound that runs out ends the run as a failure.
  task automatic wait_on(input int w, input logic val, input int n);
    int i;
    for (i = 0; i < n && pick(w) !== val; i++)
      step(1);
    check(32'(pick(w)), 32'(val));
    if (pick(w) !== val)
      results();
  endtask
  // Selects stand for one phase period, so exactly one start edge takes them.
  // Held longer, the sequencer would rightly queue them as a second access.
  task automatic request(input logic bk);
    bank = bk;
    sel_n = 5'h00;
    step(4);
    sel_n = 5'h1F;
  endtask
  task automatic scen_access(input logic bk);
    int h0;
    int h1;
    h0 = hits0;
    h1 = hits1;
    request(bk);
    wait_on(int'(bk), 1'b0, 20);
    check(32'(pick(int'(!bk))), 32'h1);
    wait_on(2, 1'b0, 4);
    wait_on(int'(bk), 1'b1, 30);
    wait_on(2, 1'b1, 30);
    step(8);
    check(32'(hits0 - h0), bk ? 32'h0 : 32'h1);
    check(32'(hits1 - h1), bk ? 32'h1 : 32'h0);
  endtask
  task automatic scen_partial();
    int i;
    for (i = 0; i < 5; i++)
    begin
      sel_n = 5'(1 << i);
      step(20);
      check(32'({b0, b1}), 32'h3);
    end
    sel_n = 5'h1F;
  endtask
  task automatic scen_refresh();
    rfq = 1'b1;
    wait_on(3, 1'b1, 20);
    wait_on(0, 1'b0, 8);
    check(32'(b1), 32'h0);
    rfq = 1'b0;
    wait_on(3, 1'b0, 40);
    wait_on(0, 1'b1, 20);
    step(8);
  endtask
  // A request arriving mid-access must be held and served once idle.
  task automatic scen_queue();
    int h1;
    h1 = hits1;
    request(1'b0);
    wait_on(0, 1'b0, 20);
    request(1'b1);
    wait_on(1, 1'b0, 40);
    check(32'(b0), 32'h1);
    wait_on(1, 1'b1, 30);
    wait_on(2, 1'b1, 30);
    step(8);
    check(32'(hits1 - h1), 32'h1);
  endtask
  initial
  begin
    rstn = 1'b0;
    rfq = 1'b0;
    bank = 1'b0;
    sel_n = 5'h1F;
    err_total = 0;
    checks_done = 0;
    step(4);
    check(32'({b0, b1, rcs, mux}), 32'hE);
    rstn = 1'b1;
    step(8);
    check(32'({b0, b1, rcs, mux}), 32'hE);
    scen_access(1'b0);
    scen_access(1'b1);
    scen_partial();
    scen_refresh();
    scen_queue();
    scen_access(1'b0);
    results();
  end
endmodule
`default_nettype wire
